/* hdl/nibble_alu_move_datapath.sv */
// Nibble accumulator datapath with its data memory, index pointer and carry flag.
// How it works
// - Working register index n addresses data memory at n plus 70H.
// - Memory-to-work move copies the direct nibble to accumulator and working register.
// - Memory-to-indexed move copies the direct nibble to accumulator and pointed location.
// - Reverse moves copy working or pointed nibble to accumulator and direct location.
// - Auto-increment forms add one to the index pointer after the operation.
// - Right shifts move bits toward bit 0, fill bit 3, write memory and accumulator.
// - Left shifts move bits toward bit 3, fill bit 0, write memory and accumulator.
// - Bit-to-carry copies bit 3 of the direct nibble into the carry flag.
// - Flags-to-memory writes carry in bit 3, zero flag in bit 2, zeros below.
// - Direct increment writes nibble plus one to memory and accumulator, updates carry.
// - Indexed increment writes pointed nibble plus one back and to accumulator.
// - Direct decrement writes nibble minus one to memory and accumulator, updates carry.
// - Indexed decrement writes pointed nibble minus one back and to accumulator.
// - Direct add-with-carry puts memory plus accumulator plus carry into accumulator only.
// - Storing direct add-with-carry also writes the sum to the direct location.
// - Indexed add-with-carry puts pointed nibble plus accumulator plus carry in accumulator.
// - Storing indexed add-with-carry also writes the sum to the pointed location.
// - Direct subtract-with-borrow adds inverted accumulator and carry; storing form writes memory.
// - Indexed subtract-with-borrow does the same on the pointed nibble, may auto-increment.
`timescale 1ns/10ps
`default_nettype none

module nibble_alu_move_datapath
    import nibble_alu_pkg::*;
(
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RESET,
    // Instruction from the decoder
    input  wire logic        OP_VALID,
    input  wire op_req_t     OP_REQ,
    input  wire ptr_load_t   PTR_LOAD,
    // Data memory read port for the rest of the core
    input  wire logic [6:0]  MEM_RD_ADDR,
    output logic      [3:0]  MEM_RD_DATA,
    // Datapath state
    output logic      [3:0]  RESULT_NIBBLE,
    output logic             CARRY_FLAG,
    output logic      [6:0]  INDEX_POINTER,
    output logic             OP_DONE
);

    typedef struct packed {
        logic [MEM_DEPTH-1:0][NIB_W-1:0] mem;
        logic [3:0]                      result_nibble_reg;
        logic                            carry_flag;
        logic [6:0]                      index_pointer;
        logic [3:0]                      rd_data;
        logic                            done;
    } state_t;

    state_t      st_r;
    state_t      st_nxt;

    logic [3:0]  dir_val;
    logic [3:0]  ptr_val;
    logic [3:0]  work_val;
    logic [6:0]  work_addr;
    logic [3:0]  alu_a;
    logic [3:0]  alu_b;
    logic        alu_cin;
    logic [4:0]  alu_sum;
    logic [3:0]  res;
    logic [6:0]  wr_addr;
    logic        wr_en;
    logic        use_alu;
    logic        upd_carry;
    logic        indexed;

    function automatic logic [6:0] work_to_addr(input logic [3:0] idx);
        work_to_addr = WORK_BASE_ADDR + {3'b000, idx};
    endfunction

    assign work_addr = work_to_addr(OP_REQ.work_reg_index);
    assign dir_val   = st_r.mem[OP_REQ.direct_addr];
    assign ptr_val   = st_r.mem[st_r.index_pointer];
    assign work_val  = st_r.mem[work_addr];
    // Carry out of bit 3 is the fifth bit of the sum; for subtraction it means no borrow.
    assign alu_sum   = {1'b0, alu_a} + {1'b0, alu_b} + {4'b0000, alu_cin};

    // The whole operation is decoded and settled within one cycle, so back to back ops see fresh data.
    always_comb
    begin
        alu_a     = dir_val;
        alu_b     = NIB_ZERO;
        alu_cin   = 1'b0;
        use_alu   = 1'b0;
        upd_carry = 1'b0;
        res       = dir_val;
        wr_addr   = OP_REQ.direct_addr;
        wr_en     = 1'b0;
        indexed   = 1'b0;
        case (OP_REQ.code)
            OP_MEM_TO_WORK:
            begin
                wr_addr = work_addr;
                wr_en   = 1'b1;
            end
            OP_MEM_TO_IDX:
            begin
                wr_addr = st_r.index_pointer;
                wr_en   = 1'b1;
                indexed = 1'b1;
            end
            OP_WORK_TO_MEM:
            begin
                res   = work_val;
                wr_en = 1'b1;
            end
            OP_IDX_TO_MEM:
            begin
                res     = ptr_val;
                wr_en   = 1'b1;
                indexed = 1'b1;
            end
            OP_SHR_ZERO:
            begin
                res   = {FILL_ZERO, dir_val[3:1]};
                wr_en = 1'b1;
            end
            OP_SHR_ONE:
            begin
                res   = {FILL_ONE, dir_val[3:1]};
                wr_en = 1'b1;
            end
            OP_SHL_ZERO:
            begin
                res   = {dir_val[2:0], FILL_ZERO};
                wr_en = 1'b1;
            end
            OP_SHL_ONE:
            begin
                res   = {dir_val[2:0], FILL_ONE};
                wr_en = 1'b1;
            end
            OP_FLAGS_TO_MEM:
            begin
                res                 = NIB_ZERO;
                res[FLAG_CARRY_BIT] = st_r.carry_flag;
                res[FLAG_ZERO_BIT]  = (st_r.result_nibble_reg == NIB_ZERO);
                wr_en               = 1'b1;
            end
            OP_INC_DIR, OP_INC_IDX:
            begin
                indexed   = (OP_REQ.code == OP_INC_IDX);
                alu_a     = indexed ? ptr_val : dir_val;
                alu_b     = NIB_ONE;
                use_alu   = 1'b1;
                upd_carry = 1'b1;
                wr_addr   = indexed ? st_r.index_pointer : OP_REQ.direct_addr;
                wr_en     = 1'b1;
            end
            OP_DEC_DIR, OP_DEC_IDX:
            begin
                // Minus one is added as all ones, so carry clear means the nibble was zero.
                indexed   = (OP_REQ.code == OP_DEC_IDX);
                alu_a     = indexed ? ptr_val : dir_val;
                alu_b     = NIB_ALL_ONES;
                use_alu   = 1'b1;
                upd_carry = 1'b1;
                wr_addr   = indexed ? st_r.index_pointer : OP_REQ.direct_addr;
                wr_en     = 1'b1;
            end
            OP_ADC_DIR, OP_ADC_DIR_STORE:
            begin
                alu_b     = st_r.result_nibble_reg;
                alu_cin   = st_r.carry_flag;
                use_alu   = 1'b1;
                upd_carry = 1'b1;
                wr_en     = (OP_REQ.code == OP_ADC_DIR_STORE);
            end
            OP_ADC_IDX, OP_ADC_IDX_STORE:
            begin
                alu_a     = ptr_val;
                alu_b     = st_r.result_nibble_reg;
                alu_cin   = st_r.carry_flag;
                use_alu   = 1'b1;
                upd_carry = 1'b1;
                indexed   = 1'b1;
                wr_addr   = st_r.index_pointer;
                wr_en     = (OP_REQ.code == OP_ADC_IDX_STORE);
            end
            OP_SBC_DIR, OP_SBC_DIR_STORE:
            begin
                alu_b     = ~st_r.result_nibble_reg;
                alu_cin   = st_r.carry_flag;
                use_alu   = 1'b1;
                upd_carry = 1'b1;
                wr_en     = (OP_REQ.code == OP_SBC_DIR_STORE);
            end
            OP_SBC_IDX, OP_SBC_IDX_STORE:
            begin
                alu_a     = ptr_val;
                alu_b     = ~st_r.result_nibble_reg;
                alu_cin   = st_r.carry_flag;
                use_alu   = 1'b1;
                upd_carry = 1'b1;
                indexed   = 1'b1;
                wr_addr   = st_r.index_pointer;
                wr_en     = (OP_REQ.code == OP_SBC_IDX_STORE);
            end
            default:
            begin
                // An undefined code keeps the accumulator, so it only pulses done.
                res = st_r.result_nibble_reg;
            end
        endcase
        if (use_alu)
        begin
            res = alu_sum[3:0];
        end
    end

    always_comb
    begin
        st_nxt         = st_r;
        st_nxt.done    = 1'b0;
        st_nxt.rd_data = st_r.mem[MEM_RD_ADDR];
        if (OP_VALID && OP_REQ.code != OP_NOP)
        begin
            st_nxt.done = 1'b1;
            if (OP_REQ.code == OP_BIT3_TO_CARRY)
            begin
                st_nxt.carry_flag = dir_val[3];
            end
            else
            begin
                st_nxt.result_nibble_reg = res;
                if (upd_carry)
                begin
                    st_nxt.carry_flag = alu_sum[4];
                end
            end
            if (wr_en)
            begin
                st_nxt.mem[wr_addr] = res;
            end
            // The pointer steps on the same edge as the write, which used the old pointer.
            if (indexed && OP_REQ.auto_inc)
            begin
                st_nxt.index_pointer = st_r.index_pointer + PTR_STEP;
            end
        end
        else if (PTR_LOAD.load)
        begin
            st_nxt.index_pointer = PTR_LOAD.value;
        end
    end

    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            st_r.mem               <= '{default: MEM_RESET};
            st_r.result_nibble_reg <= ACC_RESET;
            st_r.carry_flag        <= CARRY_RESET;
            st_r.index_pointer     <= PTR_RESET;
            st_r.rd_data           <= MEM_RESET;
            st_r.done              <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign MEM_RD_DATA   = st_r.rd_data;
    assign RESULT_NIBBLE = st_r.result_nibble_reg;
    assign CARRY_FLAG    = st_r.carry_flag;
    assign INDEX_POINTER = st_r.index_pointer;
    assign OP_DONE       = st_r.done;

    // Checks on the datapath, all in the core clock domain.
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RESET);

    logic go;
    assign go = OP_VALID && OP_REQ.code != OP_NOP;

    a_work_reg_map: assert property (go && OP_REQ.code == OP_MEM_TO_WORK |=>
        st_r.mem[7'h70 + {3'b000, $past(OP_REQ.work_reg_index)}] == $past(dir_val))
        else $error("working register move missed its 70H based address");
    a_work_move_acc: assert property (go && OP_REQ.code == OP_MEM_TO_WORK |=>
        RESULT_NIBBLE == $past(dir_val))
        else $error("memory to work move did not load the accumulator");
    a_idx_move: assert property (go && OP_REQ.code == OP_MEM_TO_IDX |=>
        st_r.mem[$past(st_r.index_pointer)] == $past(dir_val) && RESULT_NIBBLE == $past(dir_val))
        else $error("memory to indexed move wrote wrong data");
    a_reverse_move: assert property (go && OP_REQ.code == OP_WORK_TO_MEM |=>
        st_r.mem[$past(OP_REQ.direct_addr)] == $past(work_val) && RESULT_NIBBLE == $past(work_val))
        else $error("work to memory move wrote wrong data");
    a_ptr_step: assert property (go && indexed && OP_REQ.auto_inc |=>
        INDEX_POINTER == $past(st_r.index_pointer) + 7'h01)
        else $error("index pointer did not step by one");
    a_ptr_hold: assert property (go && !indexed |=>
        INDEX_POINTER == $past(st_r.index_pointer))
        else $error("index pointer moved on a direct operation");
    a_shift_right: assert property (go && OP_REQ.code == OP_SHR_ONE |=>
        RESULT_NIBBLE == {1'b1, $past(dir_val[3:1])})
        else $error("right shift with one fill is wrong");
    a_shift_left: assert property (go && OP_REQ.code == OP_SHL_ZERO |=>
        st_r.mem[$past(OP_REQ.direct_addr)] == {$past(dir_val[2:0]), 1'b0})
        else $error("left shift with zero fill is wrong");
    a_bit3_carry: assert property (go && OP_REQ.code == OP_BIT3_TO_CARRY |=>
        CARRY_FLAG == $past(dir_val[3]) && $stable(RESULT_NIBBLE))
        else $error("bit 3 was not copied to carry");
    a_flags_nibble: assert property (go && OP_REQ.code == OP_FLAGS_TO_MEM |=>
        RESULT_NIBBLE == {$past(CARRY_FLAG), $past(RESULT_NIBBLE) == 4'h0, 2'b00})
        else $error("flags nibble layout is wrong");
    a_inc_wrap: assert property (go && OP_REQ.code == OP_INC_DIR && dir_val == 4'hF |=>
        RESULT_NIBBLE == 4'h0 && CARRY_FLAG)
        else $error("increment of F did not wrap with carry");
    a_dec_zero: assert property (go && OP_REQ.code == OP_DEC_IDX && ptr_val == 4'h0 |=>
        RESULT_NIBBLE == 4'hF && !CARRY_FLAG)
        else $error("decrement of zero did not borrow");
    a_adc_nostore: assert property (go && OP_REQ.code == OP_ADC_DIR |=>
        $stable(st_r.mem) && ({CARRY_FLAG, RESULT_NIBBLE} ==
        {1'b0, $past(dir_val)} + {1'b0, $past(RESULT_NIBBLE)} + {4'h0, $past(CARRY_FLAG)}))
        else $error("add with carry result or memory is wrong");
    a_sbc_store: assert property (go && OP_REQ.code == OP_SBC_DIR_STORE |=>
        st_r.mem[$past(OP_REQ.direct_addr)] == RESULT_NIBBLE)
        else $error("storing subtract did not write memory");
    a_done_pulse: assert property (go |=> OP_DONE ##1 (OP_DONE == $past(go)))
        else $error("done did not follow the operation by one cycle");

    c_adc_idx_store: cover property (go && OP_REQ.code == OP_ADC_IDX_STORE && OP_REQ.auto_inc);
    c_sbc_borrow: cover property (go && OP_REQ.code == OP_SBC_IDX && alu_sum[4] == 1'b0);
    c_back_to_back: cover property (go ##1 go && indexed);
    c_work_move: cover property (go && OP_REQ.code == OP_WORK_TO_MEM);

endmodule

`default_nettype wire

/* hdl/nibble_alu_pkg.sv */
// Shared constants, operation codes and carrier types of the nibble datapath.
package nibble_alu_pkg;

    // Data memory geometry.
    localparam int          ADDR_W          = 7;
    localparam int          MEM_DEPTH       = 128;
    localparam int          NIB_W           = 4;

    // Working registers start at this data memory address.
    localparam logic [6:0]  WORK_BASE_ADDR  = 7'h70;

    // Values after reset.
    localparam logic [3:0]  ACC_RESET       = 4'h0;
    localparam logic        CARRY_RESET     = 1'b0;
    localparam logic [6:0]  PTR_RESET       = 7'h00;
    localparam logic [3:0]  MEM_RESET       = 4'h0;

    // Field positions of the flags nibble.
    localparam int          FLAG_CARRY_BIT  = 3;
    localparam int          FLAG_ZERO_BIT   = 2;

    // Fill values and constant operands.
    localparam logic        FILL_ZERO       = 1'b0;
    localparam logic        FILL_ONE        = 1'b1;
    localparam logic [3:0]  NIB_ONE         = 4'h1;
    localparam logic [3:0]  NIB_ALL_ONES    = 4'hF;
    localparam logic [3:0]  NIB_ZERO        = 4'h0;
    localparam logic [6:0]  PTR_STEP        = 7'h01;

    // Operation codes issued by the instruction decoder.
    typedef enum logic [4:0] {
        OP_NOP              = 5'h00,
        OP_MEM_TO_WORK      = 5'h01,
        OP_MEM_TO_IDX       = 5'h02,
        OP_WORK_TO_MEM      = 5'h03,
        OP_IDX_TO_MEM       = 5'h04,
        OP_SHR_ZERO         = 5'h05,
        OP_SHR_ONE          = 5'h06,
        OP_SHL_ZERO         = 5'h07,
        OP_SHL_ONE          = 5'h08,
        OP_BIT3_TO_CARRY    = 5'h09,
        OP_FLAGS_TO_MEM     = 5'h0A,
        OP_INC_DIR          = 5'h0B,
        OP_INC_IDX          = 5'h0C,
        OP_DEC_DIR          = 5'h0D,
        OP_DEC_IDX          = 5'h0E,
        OP_ADC_DIR          = 5'h0F,
        OP_ADC_DIR_STORE    = 5'h10,
        OP_ADC_IDX          = 5'h11,
        OP_ADC_IDX_STORE    = 5'h12,
        OP_SBC_DIR          = 5'h13,
        OP_SBC_DIR_STORE    = 5'h14,
        OP_SBC_IDX          = 5'h15,
        OP_SBC_IDX_STORE    = 5'h16
    } op_code_t;

    // One instruction as handed over by the decoder.
    typedef struct packed {
        op_code_t    code;
        logic [6:0]  direct_addr;
        logic [3:0]  work_reg_index;
        logic        auto_inc;
    } op_req_t;

    // Pointer load request from the decoder.
    typedef struct packed {
        logic        load;
        logic [6:0]  value;
    } ptr_load_t;

endpackage

/* sim/decoder_model.sv */
// Behavioural instruction decoder that drives the nibble datapath and reads its memory port.
`timescale 1ns/10ps
`default_nettype none

module decoder_model
    import nibble_alu_pkg::*;
(
    // Clock
    input  wire logic        clock,
    // Instruction side
    output var  logic        op_valid,
    output var  op_req_t     op_req,
    output var  ptr_load_t   ptr_load,
    // Memory read side
    output var  logic [6:0]  rd_addr,
    input  wire logic [3:0]  rd_data
);
    initial
    begin
        op_valid = 1'h0;
        op_req   = '0;
        ptr_load = '0;
        rd_addr  = 7'h00;
    end

    // Entered at a falling edge; the request stays up until the next issue or an idle.
    task automatic issue(input op_code_t c, input logic [6:0] a, input logic [3:0] w, input logic inc);
        op_valid = 1'h1;
        op_req   = '{code: c, direct_addr: a, work_reg_index: w, auto_inc: inc};
        @(posedge clock);
        @(negedge clock);
    endtask

    // Released fields show an inverted pattern, so a stale request can never pass for a live one.
    task automatic idle();
        op_valid = 1'h0;
        op_req   = ~op_req;
        @(posedge clock);
        @(negedge clock);
    endtask

    task automatic load_ptr(input logic [6:0] v);
        ptr_load = '{load: 1'h1, value: v};
        @(posedge clock);
        @(negedge clock);
        ptr_load = '{load: 1'h0, value: ~v};
    endtask

    task automatic peek(input logic [6:0] a, output logic [3:0] d);
        rd_addr = a;
        @(posedge clock);
        @(negedge clock);
        d = rd_data;
    endtask
endmodule

`default_nettype wire

/* sim/nibble_alu_move_datapath_tb.sv */
// Self-checking bench for the nibble datapath with a reference model of its state.
`timescale 1ns/10ps
`default_nettype none

module nibble_alu_move_datapath_tb
    import nibble_alu_pkg::*;
;
    logic        clock;
    logic        reset;
    logic        op_valid;
    op_req_t     op_req;
    ptr_load_t   ptr_load;
    logic [6:0]  rd_addr;
    logic [3:0]  rd_data;
    logic [3:0]  result_nibble;
    logic        carry_flag;
    logic [6:0]  index_pointer;
    logic        op_done;
    logic [3:0]  m_mem [MEM_DEPTH];
    logic [3:0]  m_acc;
    logic        m_cf;
    logic [6:0]  m_ptr;
    int          n_mismatch;
    int          checked;

    initial
    begin
        clock = 1'h0;
    end

    always #2 clock = ~clock;

    nibble_alu_move_datapath DUT (
        .CLOCK         (clock),
        .RESET         (reset),
        .OP_VALID      (op_valid),
        .OP_REQ        (op_req),
        .PTR_LOAD      (ptr_load),
        .MEM_RD_ADDR   (rd_addr),
        .MEM_RD_DATA   (rd_data),
        .RESULT_NIBBLE (result_nibble),
        .CARRY_FLAG    (carry_flag),
        .INDEX_POINTER (index_pointer),
        .OP_DONE       (op_done)
    );

    decoder_model dec (
        .clock    (clock),
        .op_valid (op_valid),
        .op_req   (op_req),
        .ptr_load (ptr_load),
        .rd_addr  (rd_addr),
        .rd_data  (rd_data)
    );

    task automatic cmp4(input string what, input logic [3:0] exp, input logic [3:0] got);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp1(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic cmp7(input string what, input logic [6:0] exp, input logic [6:0] got);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Issues one operation, steps the reference model and compares the state one cycle later.
    task automatic exec(input op_code_t c, input logic [6:0] a, input logic [3:0] w, input logic inc);
        logic [6:0] wa;
        logic [6:0] src;
        logic [6:0] dst;
        logic [3:0] d;
        logic [4:0] s;
        logic       ix;
        logic       st;
        ix  = c inside {OP_MEM_TO_IDX, OP_IDX_TO_MEM, OP_INC_IDX, OP_DEC_IDX, OP_ADC_IDX, OP_ADC_IDX_STORE,
                        OP_SBC_IDX, OP_SBC_IDX_STORE};
        wa  = WORK_BASE_ADDR + {3'h0, w};
        src = (ix && c != OP_MEM_TO_IDX) ? m_ptr : ((c == OP_WORK_TO_MEM) ? wa : a);
        dst = (c == OP_MEM_TO_WORK) ? wa : ((ix && c != OP_IDX_TO_MEM) ? m_ptr : a);
        d   = m_mem[src];
        s   = {m_cf, m_acc};
        st  = (c <= OP_SBC_IDX_STORE) && !(c inside {OP_NOP, OP_BIT3_TO_CARRY, OP_ADC_DIR, OP_ADC_IDX,
                                                      OP_SBC_DIR, OP_SBC_IDX});
        case (c)
            OP_MEM_TO_WORK, OP_MEM_TO_IDX, OP_WORK_TO_MEM, OP_IDX_TO_MEM: s = {m_cf, d};
            OP_SHR_ZERO:      s = {m_cf, FILL_ZERO, d[3:1]};
            OP_SHR_ONE:       s = {m_cf, FILL_ONE, d[3:1]};
            OP_SHL_ZERO:      s = {m_cf, d[2:0], FILL_ZERO};
            OP_SHL_ONE:       s = {m_cf, d[2:0], FILL_ONE};
            OP_BIT3_TO_CARRY: s = {d[3], m_acc};
            OP_FLAGS_TO_MEM:  s = {m_cf, m_cf, m_acc == NIB_ZERO, 2'h0};
            OP_INC_DIR, OP_INC_IDX: s = {1'h0, d} + 5'h01;
            OP_DEC_DIR, OP_DEC_IDX: s = {1'h0, d} + 5'h0F;
            OP_ADC_DIR, OP_ADC_DIR_STORE, OP_ADC_IDX, OP_ADC_IDX_STORE: s = {1'h0, d} + {1'h0, m_acc} + {4'h0, m_cf};
            OP_SBC_DIR, OP_SBC_DIR_STORE, OP_SBC_IDX, OP_SBC_IDX_STORE: s = {1'h0, d} + {1'h0, ~m_acc} + {4'h0, m_cf};
            default: s = {m_cf, m_acc};
        endcase
        dec.issue(c, a, w, inc);
        m_acc = s[3:0];
        m_cf  = s[4];
        if (st)
            m_mem[dst] = s[3:0];
        if (ix && inc)
            m_ptr = m_ptr + PTR_STEP;
        cmp4("accumulator", m_acc, result_nibble);
        cmp1("carry", m_cf, carry_flag);
        cmp7("pointer", m_ptr, index_pointer);
        cmp1("done", c != OP_NOP, op_done);
    endtask

    task automatic chk_mem(input logic [6:0] a);
        logic [3:0] v;
        dec.peek(a, v);
        cmp4("memory", m_mem[a], v);
    endtask

    task automatic set_ptr(input logic [6:0] v);
        dec.idle();
        dec.load_ptr(v);
        m_ptr = v;
        cmp7("pointer", v, index_pointer);
    endtask

    task automatic t_reset();
        cmp4("accumulator", ACC_RESET, result_nibble);
        cmp1("carry", CARRY_RESET, carry_flag);
        cmp7("pointer", PTR_RESET, index_pointer);
        cmp1("done", 1'h0, op_done);
        chk_mem(7'h7F);
        $display("test reset done");
    endtask

    task automatic t_moves();
        repeat (3) exec(OP_INC_DIR, 7'h05, 4'h0, 1'h0);
        exec(OP_MEM_TO_WORK, 7'h05, 4'hF, 1'h0);
        exec(OP_INC_DIR, 7'h05, 4'h0, 1'h0);
        set_ptr(7'h20);
        exec(OP_MEM_TO_IDX, 7'h05, 4'h0, 1'h1);
        exec(OP_WORK_TO_MEM, 7'h06, 4'hF, 1'h0);
        set_ptr(7'h20);
        exec(OP_IDX_TO_MEM, 7'h07, 4'h0, 1'h1);
        dec.idle();
        chk_mem(7'h7F);
        chk_mem(7'h0F);
        chk_mem(7'h20);
        chk_mem(7'h06);
        chk_mem(7'h07);
        $display("test moves done");
    endtask

    task automatic t_shift();
        op_code_t sh [4] = '{OP_SHR_ONE, OP_SHR_ZERO, OP_SHL_ONE, OP_SHL_ZERO};
        foreach (sh[i]) exec(sh[i], 7'h05, 4'h0, 1'h0);
        dec.idle();
        chk_mem(7'h05);
        $display("test shift done");
    endtask

    task automatic t_flags();
        exec(OP_DEC_DIR, 7'h09, 4'h0, 1'h0);
        exec(OP_BIT3_TO_CARRY, 7'h09, 4'h0, 1'h0);
        exec(OP_FLAGS_TO_MEM, 7'h0A, 4'h0, 1'h0);
        exec(OP_INC_DIR, 7'h09, 4'h0, 1'h0);
        exec(OP_FLAGS_TO_MEM, 7'h0B, 4'h0, 1'h0);
        exec(OP_BIT3_TO_CARRY, 7'h05, 4'h0, 1'h0);
        exec(OP_FLAGS_TO_MEM, 7'h0C, 4'h0, 1'h0);
        dec.idle();
        chk_mem(7'h09);
        chk_mem(7'h0A);
        chk_mem(7'h0B);
        $display("test flags done");
    endtask

    task automatic t_arith();
        set_ptr(7'h7D);
        exec(OP_INC_IDX, 7'h00, 4'h0, 1'h1);
        exec(OP_DEC_IDX, 7'h00, 4'h0, 1'h1);
        exec(OP_ADC_DIR, 7'h05, 4'h0, 1'h0);
        exec(OP_ADC_DIR_STORE, 7'h7F, 4'h0, 1'h0);
        exec(OP_ADC_IDX, 7'h00, 4'h0, 1'h1);
        exec(OP_ADC_IDX_STORE, 7'h00, 4'h0, 1'h0);
        exec(OP_SBC_DIR, 7'h09, 4'h0, 1'h0);
        exec(OP_SBC_DIR_STORE, 7'h0B, 4'h0, 1'h0);
        exec(OP_SBC_IDX, 7'h00, 4'h0, 1'h1);
        exec(OP_SBC_IDX_STORE, 7'h00, 4'h0, 1'h1);
        exec(OP_NOP, 7'h05, 4'h0, 1'h1);
        exec(op_code_t'(5'h1F), 7'h05, 4'h0, 1'h1);
        dec.idle();
        chk_mem(7'h7D);
        chk_mem(7'h7E);
        chk_mem(7'h7F);
        chk_mem(7'h00);
        chk_mem(7'h0B);
        chk_mem(7'h01);
        $display("test arith done");
    endtask

    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        n_mismatch = 0;
        checked    = 0;
        reset      = 1'h1;
        m_acc      = ACC_RESET;
        m_cf       = CARRY_RESET;
        m_ptr      = PTR_RESET;
        foreach (m_mem[i]) m_mem[i] = MEM_RESET;
        repeat (12) @(negedge clock);
        reset = 1'h0;
        @(negedge clock);
        t_reset();
        t_moves();
        t_shift();
        t_flags();
        t_arith();
        tally_and_finish();
    end

    // A hang is cut short after a fixed number of cycles.
    initial
    begin
        repeat (5000) @(posedge clock);
        n_mismatch++;
        $display("mismatch watchdog expected finish seen hang");
        tally_and_finish();
    end
endmodule

`default_nettype wire
